// ===== shared/ddr_dev_pkg.sv
// constants, field layouts and pin groups of the ddr sdram device model
package ddr_dev_pkg;

  // ==========================================================================
  // geometry
  localparam int ROW_W     = 13;
  localparam int BA_W      = 2;
  localparam int DQ_W      = 8;
  localparam int NBANK     = 4;
  localparam int ST_ROW_W  = 2;
  localparam int ST_COL_W  = 6;
  localparam int MEM_AW    = BA_W + ST_ROW_W + ST_COL_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ==========================================================================
  // wishbone register offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_EMODE  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ERR    = 8'h0c;
  localparam logic [7:0] OFS_CTRL   = 8'h10;

  // ==========================================================================
  // mode register fields and codes
  localparam int MR_BL_LSB      = 0;
  localparam int MR_BT_BIT      = 3;
  localparam int MR_CL_LSB      = 4;
  localparam int MR_OP_LSB      = 7;
  localparam int MR_DLL_RST_BIT = 8;
  localparam int AP_BIT         = 10;
  localparam logic [2:0] BL_CODE_2  = 3'h1;
  localparam logic [2:0] BL_CODE_4  = 3'h2;
  localparam logic [2:0] BL_CODE_8  = 3'h3;
  localparam logic [2:0] CL_CODE_2  = 3'h2;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  localparam logic [1:0] BA_MODE    = 2'h0;
  localparam logic [1:0] BA_EMODE   = 2'h1;
  localparam logic [5:0] OP_NORMAL  = 6'h00;
  localparam logic [5:0] OP_DLL_RST = 6'h02;

  // ==========================================================================
  // reset values and counts
  localparam logic [12:0] MODE_RST     = 13'h0000;
  localparam logic [12:0] EMODE_RST    = 13'h0000;
  localparam logic        CTRL_DRV_RST = 1'b1;
  localparam int          DLL_LOCK_CLKS = 200;
  localparam int          AREF_NEEDED  = 2;
  localparam logic [3:0]  LAT_HALF_CL2  = 4'h4;
  localparam logic [3:0]  LAT_HALF_CL25 = 4'h5;

  // ==========================================================================
  // error flag positions
  localparam int ERR_NOACT    = 0;
  localparam int ERR_MRS_BUSY = 1;
  localparam int ERR_BL       = 2;
  localparam int ERR_DLL      = 3;
  localparam int ERR_OP       = 4;
  localparam int ERR_W        = 5;

  // ==========================================================================
  // types
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic       dqs;
    logic       dm;
    logic [7:0] dq;
  } data_pins_t;

  typedef enum logic [1:0] {S_IDLE, S_RD_WAIT, S_RD_DATA, S_WR_DATA} state_t;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS,
                            CMD_BST} cmd_t;

endpackage : ddr_dev_pkg

// ===== rtl/sync_2ff.sv
// two flip-flop synchroniser for a group of pin inputs
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input  logic         clk_i,
  input  logic         rst_i,
  // data
  input  logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : sync_2ff

// ===== rtl/burst_col.sv
// column offset of one burst beat inside its aligned block
module burst_col (
  // burst description
  input  logic [2:0] start_i,
  input  logic [2:0] beat_i,
  input  logic [2:0] mask_i,
  input  logic       ilv_i,
  // result
  output logic [2:0] offs_o
);

  logic [2:0] seq;
  logic [2:0] ord;

  always_comb begin
    seq    = 3'(start_i + beat_i);
    ord    = ilv_i ? (start_i ^ beat_i) : seq;
    offs_o = (start_i & ~mask_i) | (ord & mask_i);
  end

endmodule : burst_col

// ===== rtl/ddr_dev_core.sv
// ddr sdram device: command decode, mode registers, banks and burst data path
// ==========================================================================
// Functional notes
// (RL1) reads and writes need an activated bank first; then burst of set length
// (RL2) activate takes two bank bits and thirteen row bits
// (RL3) address with read or write gives the first column of the burst
// (RL4) one double word per clock at core, two half-clock beats at pins
// (RL5) four independently addressed banks
// (RL6) controller waits 200 us after power before any command
// (RL7) data and strobe outputs stay off except during read data
// (RL8) controller then issues nop and raises clock enable
// (RL9) controller precharges all, sets extended mode, then mode with dll reset
// (RL10) at least 200 clocks between dll reset and a read
// (RL11) controller precharges all, then two auto refreshes
// (RL12) controller rewrites mode without dll reset before normal use
// (RL13) mode register set with bank bits 00 loads the mode register
// (RL14) dll reset bit clears itself, other bits stay
// (RL15) bits 2:0 length, 3 type, 6:4 latency, 12:7 operating mode
// (RL16) mode register only written with all banks idle; code still loads it with banks open, setting ERR_MRS_BUSY
// (RL17) lengths 2, 4, 8 in both orders; other codes reserved
// (RL18) burst stays in an aligned block of burst length and wraps
// (RL19) upper column bits pick the block, low bits the start
// (RL20) one programmed length for reads and writes
// (RL21) read latency 2 or 2.5 clocks
// (RL22) bit 3 picks sequential or interleaved order
// (RL23) operating mode zero is normal, only bit 8 set is dll reset
// (RL24) bank bits 01 load the extended mode register
// (RL25) controller sends nops while it waits
module ddr_dev_core (
  // clock and reset
  input  logic                     clk_i,
  input  logic                     rst_i,
  // wishbone slave
  input  logic                     wb_cyc_i,
  input  logic                     wb_stb_i,
  input  logic                     wb_we_i,
  input  logic [7:0]               wb_adr_i,
  input  logic [3:0]               wb_sel_i,
  input  logic [31:0]              wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // memory pins
  input  logic                     ck_i,
  input  ddr_dev_pkg::cmd_pins_t   cmd_i,
  input  ddr_dev_pkg::data_pins_t  dat_i,
  output logic [7:0]               dq_o,
  output logic                     dq_oe_o,
  output logic                     dqs_o,
  output logic                     dqs_oe_o
);

  // ==========================================================================
  // pin synchronisers and clock edges
  logic                    ck_s;
  logic                    ck_q;
  logic                    dqs_q;
  ddr_dev_pkg::cmd_pins_t  cmd_s;
  ddr_dev_pkg::data_pins_t dat_s;

  sync_2ff #(.W(1)) u_sync_ck (.clk_i(clk_i), .rst_i(rst_i), .d_i(ck_i), .q_o(ck_s));
  sync_2ff #(.W($bits(ddr_dev_pkg::cmd_pins_t))) u_sync_cmd (
    .clk_i(clk_i), .rst_i(rst_i), .d_i(cmd_i), .q_o(cmd_s));
  sync_2ff #(.W($bits(ddr_dev_pkg::data_pins_t))) u_sync_dat (
    .clk_i(clk_i), .rst_i(rst_i), .d_i(dat_i), .q_o(dat_s));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_q  <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      ck_q  <= ck_s;
      dqs_q <= dat_s.dqs;
    end
  end

  logic ck_rise;
  logic ck_edge;
  logic dqs_edge;
  assign ck_rise  = ck_s & ~ck_q;
  assign ck_edge  = ck_s ^ ck_q;
  assign dqs_edge = dat_s.dqs ^ dqs_q;

  // ==========================================================================
  // command decode
  ddr_dev_pkg::cmd_t   cmd;
  ddr_dev_pkg::state_t st_q;
  logic [3:0]          bank_open_q;
  logic                mrs_mode;
  logic                mrs_ext;
  logic                rd_go;
  logic                wr_go;

  always_comb begin
    cmd = ddr_dev_pkg::CMD_NOP;
    if (ck_rise && cmd_s.cke && !cmd_s.cs_n) begin
      case ({cmd_s.ras_n, cmd_s.cas_n, cmd_s.we_n})
        3'h3:    cmd = ddr_dev_pkg::CMD_ACT;
        3'h5:    cmd = ddr_dev_pkg::CMD_RD;
        3'h4:    cmd = ddr_dev_pkg::CMD_WR;
        3'h2:    cmd = ddr_dev_pkg::CMD_PRE;
        3'h1:    cmd = ddr_dev_pkg::CMD_REF;
        3'h0:    cmd = ddr_dev_pkg::CMD_MRS;
        3'h6:    cmd = ddr_dev_pkg::CMD_BST;
        default: cmd = ddr_dev_pkg::CMD_NOP;
      endcase
    end
  end

  assign mrs_mode = (cmd == ddr_dev_pkg::CMD_MRS) && (cmd_s.ba == ddr_dev_pkg::BA_MODE); // RL13
  assign mrs_ext  = (cmd == ddr_dev_pkg::CMD_MRS) && (cmd_s.ba == ddr_dev_pkg::BA_EMODE); // RL24
  assign rd_go    = (cmd == ddr_dev_pkg::CMD_RD) && (st_q == ddr_dev_pkg::S_IDLE)
                    && bank_open_q[cmd_s.ba]; // RL1
  assign wr_go    = (cmd == ddr_dev_pkg::CMD_WR) && (st_q == ddr_dev_pkg::S_IDLE)
                    && bank_open_q[cmd_s.ba]; // RL1

  // ==========================================================================
  // mode registers and dll lock count
  logic [12:0] mode_q;
  logic [12:0] emode_q;
  logic [7:0]  dll_cnt_q;
  logic        dll_ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q  <= ddr_dev_pkg::MODE_RST;
      emode_q <= ddr_dev_pkg::EMODE_RST;
    end else begin
      if (mrs_mode) begin
        mode_q <= cmd_s.addr; // RL13 RL15
      end else if (mode_q[ddr_dev_pkg::MR_DLL_RST_BIT]) begin
        mode_q[ddr_dev_pkg::MR_DLL_RST_BIT] <= 1'b0; // RL14
      end
      if (mrs_ext) begin
        emode_q <= cmd_s.addr; // RL24
      end
    end
  end

  assign dll_ready = (dll_cnt_q >= 8'(ddr_dev_pkg::DLL_LOCK_CLKS));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_cnt_q <= '0;
    end else if (mrs_mode && cmd_s.addr[ddr_dev_pkg::MR_DLL_RST_BIT]) begin
      dll_cnt_q <= '0; // RL23
    end else if (ck_rise && !dll_ready) begin
      dll_cnt_q <= 8'(dll_cnt_q + 8'h01); // RL10
    end
  end

  // reserved length codes, length and latency
  logic       bl_bad;
  logic       cl25;
  always_comb begin
    bl_bad = 1'b0;
    unique case (cmd_s.addr[2:0])
      ddr_dev_pkg::BL_CODE_2, ddr_dev_pkg::BL_CODE_4, ddr_dev_pkg::BL_CODE_8: bl_bad = 1'b0;
      default: bl_bad = 1'b1; // RL17
    endcase
  end
  logic [1:0] len_mode;
  always_comb begin
    unique case (mode_q[2:0])
      ddr_dev_pkg::BL_CODE_4: len_mode = 2'h2;
      ddr_dev_pkg::BL_CODE_8: len_mode = 2'h3;
      default:                len_mode = 2'h1;
    endcase
  end
  assign cl25 = (mode_q[6:4] == ddr_dev_pkg::CL_CODE_25); // RL21

  // ==========================================================================
  // banks, rows, refresh and init tracking
  logic [12:0] row_q [ddr_dev_pkg::NBANK];
  logic [1:0]  bank_q;
  logic        apre_q;
  logic        burst_end;
  logic [1:0]  ref_cnt_q;
  logic        init_done_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_open_q <= '0;
      for (int b = 0; b < ddr_dev_pkg::NBANK; b++) begin
        row_q[b] <= '0;
      end
    end else begin
      if (cmd == ddr_dev_pkg::CMD_ACT) begin
        bank_open_q[cmd_s.ba] <= 1'b1; // RL2 RL5
        row_q[cmd_s.ba]       <= cmd_s.addr; // RL2
      end else if (cmd == ddr_dev_pkg::CMD_PRE) begin
        if (cmd_s.addr[ddr_dev_pkg::AP_BIT]) begin
          bank_open_q <= '0;
        end else begin
          bank_open_q[cmd_s.ba] <= 1'b0;
        end
      end else if (burst_end && apre_q) begin
        bank_open_q[bank_q] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_q   <= '0;
      init_done_q <= 1'b0;
    end else begin
      if (cmd == ddr_dev_pkg::CMD_REF && bank_open_q == 4'h0 && ref_cnt_q != 2'h3) begin
        ref_cnt_q <= 2'(ref_cnt_q + 2'h1);
      end
      if (mrs_mode && !cmd_s.addr[ddr_dev_pkg::MR_DLL_RST_BIT]
          && ref_cnt_q >= 2'(ddr_dev_pkg::AREF_NEEDED)) begin
        init_done_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // burst sequencing
  logic [3:0]          lat_q;
  logic [3:0]          beat_q;
  logic [1:0]          len_q;
  logic                ilv_q;
  logic [5:0]          col_q;
  logic [3:0]          bl_beats;
  logic [2:0]          blk_mask;
  logic [2:0]          offs_a;
  logic [2:0]          offs_b;
  logic                emit;
  logic                ctrl_drv_q;

  assign bl_beats = {len_q == 2'h3, len_q == 2'h2, len_q == 2'h1, 1'b0}; // RL17
  assign blk_mask = {len_q == 2'h3, len_q != 2'h1, 1'b1}; // RL19
  assign emit     = ck_edge && (((st_q == ddr_dev_pkg::S_RD_WAIT) && (lat_q == 4'h1))
                    || ((st_q == ddr_dev_pkg::S_RD_DATA) && (beat_q != bl_beats)));
  assign burst_end = ((st_q == ddr_dev_pkg::S_RD_DATA) && ck_edge && (beat_q == bl_beats))
                     || ((st_q == ddr_dev_pkg::S_WR_DATA) && (beat_q == bl_beats));

  burst_col u_col_a (.start_i(col_q[2:0]), .beat_i({beat_q[2:1], 1'b0}),
                     .mask_i(blk_mask), .ilv_i(ilv_q), .offs_o(offs_a)); // RL18
  burst_col u_col_b (.start_i(col_q[2:0]), .beat_i({beat_q[2:1], 1'b1}),
                     .mask_i(blk_mask), .ilv_i(ilv_q), .offs_o(offs_b)); // RL18

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ddr_dev_pkg::S_IDLE;
      lat_q  <= '0;
      beat_q <= '0;
      len_q  <= 2'h1;
      ilv_q  <= 1'b0;
      col_q  <= '0;
      bank_q <= '0;
      apre_q <= 1'b0;
    end else begin
      unique case (st_q)
        ddr_dev_pkg::S_IDLE: begin
          if (rd_go || wr_go) begin
            st_q   <= rd_go ? ddr_dev_pkg::S_RD_WAIT : ddr_dev_pkg::S_WR_DATA; // RL1
            lat_q  <= cl25 ? ddr_dev_pkg::LAT_HALF_CL25 : ddr_dev_pkg::LAT_HALF_CL2; // RL21
            beat_q <= '0;
            len_q  <= len_mode; // RL20
            ilv_q  <= mode_q[ddr_dev_pkg::MR_BT_BIT]; // RL22
            col_q  <= cmd_s.addr[5:0]; // RL3
            bank_q <= cmd_s.ba;
            apre_q <= cmd_s.addr[ddr_dev_pkg::AP_BIT];
          end
        end
        ddr_dev_pkg::S_RD_WAIT: begin
          if (emit) begin
            st_q   <= ddr_dev_pkg::S_RD_DATA;
            beat_q <= 4'h1;
          end else if (ck_edge) begin
            lat_q <= 4'(lat_q - 4'h1);
          end
        end
        ddr_dev_pkg::S_RD_DATA: begin
          if (burst_end) begin
            st_q <= ddr_dev_pkg::S_IDLE; // RL17
          end else if (emit) begin
            beat_q <= 4'(beat_q + 4'h1);
          end
        end
        ddr_dev_pkg::S_WR_DATA: begin
          if (burst_end) begin
            st_q <= ddr_dev_pkg::S_IDLE;
          end else if (dqs_edge) begin
            beat_q <= 4'(beat_q + 4'h1);
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // core array, double-word access and pin data
  logic [7:0]                 mem [ddr_dev_pkg::MEM_DEPTH];
  logic [ddr_dev_pkg::MEM_AW-1:0] adr_a;
  logic [ddr_dev_pkg::MEM_AW-1:0] adr_b;
  logic [7:0]                 rd_hi_q;
  logic [7:0]                 wr_lo_q;
  logic                       wr_lo_m_q;
  logic [1:0]                 row_lo;

  assign row_lo = row_q[bank_q][1:0];
  assign adr_a  = {bank_q, row_lo, col_q[5:3], offs_a};
  assign adr_b  = {bank_q, row_lo, col_q[5:3], offs_b};

  always_ff @(posedge clk_i) begin
    if ((st_q == ddr_dev_pkg::S_WR_DATA) && dqs_edge && (beat_q != bl_beats) && beat_q[0]) begin
      if (!wr_lo_m_q) begin
        mem[adr_a] <= wr_lo_q; // RL4
      end
      if (!dat_s.dm) begin
        mem[adr_b] <= dat_s.dq; // RL4
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_lo_q   <= '0;
      wr_lo_m_q <= 1'b0;
    end else if ((st_q == ddr_dev_pkg::S_WR_DATA) && dqs_edge && !beat_q[0]) begin
      wr_lo_q   <= dat_s.dq;
      wr_lo_m_q <= dat_s.dm;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_o     <= '0;
      rd_hi_q  <= '0;
      dq_oe_o  <= 1'b0;
      dqs_o    <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else if (emit) begin
      dq_oe_o  <= ctrl_drv_q; // RL7
      dqs_oe_o <= ctrl_drv_q; // RL7
      dqs_o    <= ~beat_q[0];
      if (!beat_q[0]) begin
        dq_o    <= mem[adr_a]; // RL4
        rd_hi_q <= mem[adr_b]; // RL4
      end else begin
        dq_o <= rd_hi_q; // RL4
      end
    end else if (st_q != ddr_dev_pkg::S_RD_DATA || burst_end) begin
      dq_oe_o  <= 1'b0; // RL7
      dqs_oe_o <= 1'b0;
      dqs_o    <= 1'b0;
    end
  end

  // ==========================================================================
  // error flags and wishbone registers
  logic [ddr_dev_pkg::ERR_W-1:0] err_q;
  logic [ddr_dev_pkg::ERR_W-1:0] err_set;
  logic                          wb_wr;

  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  always_comb begin
    err_set = '0;
    err_set[ddr_dev_pkg::ERR_NOACT] = (cmd == ddr_dev_pkg::CMD_RD || cmd == ddr_dev_pkg::CMD_WR)
                                      && !bank_open_q[cmd_s.ba]; // RL1
    err_set[ddr_dev_pkg::ERR_MRS_BUSY] = (cmd == ddr_dev_pkg::CMD_MRS)
                                         && (bank_open_q != 4'h0); // RL16
    err_set[ddr_dev_pkg::ERR_BL] = mrs_mode && (bl_bad
                                   || ((cmd_s.addr[6:4] != ddr_dev_pkg::CL_CODE_2)
                                   && (cmd_s.addr[6:4] != ddr_dev_pkg::CL_CODE_25))); // RL17 RL21
    err_set[ddr_dev_pkg::ERR_DLL] = (cmd == ddr_dev_pkg::CMD_RD) && !dll_ready; // RL10
    err_set[ddr_dev_pkg::ERR_OP] = (mrs_mode && (cmd_s.addr[12:7] != ddr_dev_pkg::OP_NORMAL)
                                   && (cmd_s.addr[12:7] != ddr_dev_pkg::OP_DLL_RST))
                                   || ((cmd == ddr_dev_pkg::CMD_MRS) && cmd_s.ba[1]); // RL23
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q      <= '0;
      ctrl_drv_q <= ddr_dev_pkg::CTRL_DRV_RST;
    end else begin
      if (wb_wr && wb_adr_i == ddr_dev_pkg::OFS_ERR) begin
        err_q <= (err_q & ~wb_dat_i[ddr_dev_pkg::ERR_W-1:0]) | err_set;
      end else begin
        err_q <= err_q | err_set;
      end
      if (wb_wr && wb_adr_i == ddr_dev_pkg::OFS_CTRL) begin
        ctrl_drv_q <= wb_dat_i[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        ddr_dev_pkg::OFS_MODE:   wb_dat_o <= {19'h0_0000, mode_q};
        ddr_dev_pkg::OFS_EMODE:  wb_dat_o <= {19'h0_0000, emode_q};
        ddr_dev_pkg::OFS_STATUS: wb_dat_o <= {23'h00_0000, init_done_q,
                                  st_q != ddr_dev_pkg::S_IDLE, ref_cnt_q, dll_ready, bank_open_q};
        ddr_dev_pkg::OFS_ERR:    wb_dat_o <= {27'h000_0000, err_q};
        ddr_dev_pkg::OFS_CTRL:   wb_dat_o <= {31'h0000_0000, ctrl_drv_q};
        default:                 wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // assertions
  property p_act_row;
    @(posedge clk_i) disable iff (rst_i)
    (cmd == ddr_dev_pkg::CMD_ACT) |=> bank_open_q[$past(cmd_s.ba)]
                                      && (row_q[$past(cmd_s.ba)] == $past(cmd_s.addr));
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate did not open row"); // RL2

  property p_mrs_write;
    @(posedge clk_i) disable iff (rst_i)
    mrs_mode |=> (mode_q == $past(cmd_s.addr));
  endproperty
  a_mrs_write: assert property (p_mrs_write) else $error("mode register not loaded"); // RL13

  property p_a8_clear;
    @(posedge clk_i) disable iff (rst_i)
    (mode_q[8] && !mrs_mode) |=> !mode_q[8] && (mode_q[7:0] == $past(mode_q[7:0]));
  endproperty
  a_a8_clear: assert property (p_a8_clear) else $error("dll reset bit did not self clear"); // RL14

  property p_emrs;
    @(posedge clk_i) disable iff (rst_i)
    mrs_ext |=> (emode_q == $past(cmd_s.addr)) && (mode_q[7:0] == $past(mode_q[7:0]));
  endproperty
  a_emrs: assert property (p_emrs) else $error("extended mode register not loaded"); // RL24

  property p_oe_read;
    @(posedge clk_i) disable iff (rst_i)
    (dq_oe_o || dqs_oe_o) |-> (st_q == ddr_dev_pkg::S_RD_DATA);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("pins driven outside read data"); // RL7

  property p_cl_load;
    @(posedge clk_i) disable iff (rst_i)
    rd_go |=> (lat_q == ($past(cl25) ? ddr_dev_pkg::LAT_HALF_CL25 : ddr_dev_pkg::LAT_HALF_CL2));
  endproperty
  a_cl_load: assert property (p_cl_load) else $error("wrong read latency loaded"); // RL21

  property p_burst_end;
    @(posedge clk_i) disable iff (rst_i)
    ((st_q == ddr_dev_pkg::S_RD_DATA) && ck_edge && (beat_q == bl_beats))
      |=> (st_q == ddr_dev_pkg::S_IDLE) && !dq_oe_o;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("read burst length wrong"); // RL20

  // block mask rebuilt from the length alone
  logic [2:0] blk_ref;
  assign blk_ref = 3'((4'h1 << len_q) - 4'h1);

  property p_block;
    @(posedge clk_i) disable iff (rst_i)
    (st_q != ddr_dev_pkg::S_IDLE) |-> (((offs_a ^ col_q[2:0]) & ~blk_ref) == 3'h0)
                                     && (((offs_b ^ col_q[2:0]) & ~blk_ref) == 3'h0);
  endproperty
  a_block: assert property (p_block) else $error("burst left its column block"); // RL18

  property p_noact;
    @(posedge clk_i) disable iff (rst_i)
    ((cmd == ddr_dev_pkg::CMD_RD) && !bank_open_q[cmd_s.ba]) |=> err_q[0] && (st_q == $past(st_q));
  endproperty
  a_noact: assert property (p_noact) else $error("access to idle bank not flagged"); // RL1

  property p_pair;
    @(posedge clk_i) disable iff (rst_i)
    (emit && beat_q[0]) |=> (dq_o == $past(rd_hi_q)) && !dqs_o;
  endproperty
  a_pair: assert property (p_pair) else $error("second half of word wrong"); // RL4

endmodule : ddr_dev_core

// ===== dv/ddr_ctl_model.sv
// memory controller model: free-running ck, commands and write bursts
module ddr_ctl_model (
  // clock
  input  wire logic              clk_i,
  // memory pins
  output logic                   ck_o,
  output ddr_dev_pkg::cmd_pins_t  cmd_o,
  output ddr_dev_pkg::data_pins_t dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_q = 3'h0;
  logic       wr_on = 1'b0;
  logic [2:0] enc [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
  initial begin
    ck_o = 1'b0;
    dat_o = '0;
    cmd_o = {5'h0f, 15'h0000};
  end
  // ==========================================================================
  // ck of eight clk periods; released dq never keeps its last value
  always @(posedge clk_i) begin
    div_q <= div_q + 3'h1;
    if (div_q[1:0] == 2'h3) ck_o <= ~ck_o;
    if (!wr_on) dat_o.dq <= ~dat_o.dq;
  end
  // ==========================================================================
  // one command, set while ck is low, nop afterwards
  task automatic send(input ddr_dev_pkg::cmd_t c, input logic [1:0] b, input logic [12:0] a);
    @(negedge ck_o);
    @(posedge clk_i);
    cmd_o <= {1'b1, 1'b0, enc[c], b, a};
    @(negedge ck_o);
    @(posedge clk_i);
    cmd_o <= {1'b1, 1'b0, 3'h7, b, a};
  endtask : send
  // four write beats, strobe centred in each
  task automatic wr4(input logic [31:0] d);
    wr_on = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      dat_o.dq <= d[8*i +: 8];
      repeat (2) @(posedge clk_i);
      dat_o.dqs <= ~dat_o.dqs;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    wr_on = 1'b0;
  endtask : wr4
endmodule : ddr_ctl_model

// ===== dv/ddr_dev_core_test.sv
// self-checking bench of the ddr sdram device core
module ddr_dev_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] ba; logic [12:0] a; logic [7:0] ofs; logic [31:0] exp;} row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, wen = 1'b0, ack, ck;
  logic dq_oe, dqs, dqs_oe, oe_q = 1'b0, dqs_q = 1'b0;
  logic [7:0] adr = 8'h00, dq;
  logic [31:0] wdat = 32'h0000_0000, rd, r, cap_q = 32'h0000_0000;
  ddr_dev_pkg::cmd_pins_t cmd;
  ddr_dev_pkg::data_pins_t dat;
  int failures = 0, n_compared = 0;
  row_t rows [4] = '{
    '{2'h1, 13'h0002, ddr_dev_pkg::OFS_EMODE, 32'h0000_0002},
    '{2'h0, 13'h0122, ddr_dev_pkg::OFS_MODE, 32'h0000_0022},
    '{2'h0, 13'h006b, ddr_dev_pkg::OFS_MODE, 32'h0000_006b},
    '{2'h0, 13'h0022, ddr_dev_pkg::OFS_MODE, 32'h0000_0022}};
  ddr_dev_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rd),
    .wb_ack_o(ack), .ck_i(ck), .cmd_i(cmd), .dat_i(dat), .dq_o(dq), .dq_oe_o(dq_oe),
    .dqs_o(dqs), .dqs_oe_o(dqs_oe));
  ddr_ctl_model ctl (.clk_i(clk_i), .ck_o(ck), .cmd_o(cmd), .dat_o(dat));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================================
  // read beats, one per strobe change while driven
  always @(posedge clk_i) begin
    if (dq_oe && (!oe_q || dqs != dqs_q)) cap_q <= {dq, cap_q[31:8]};
    oe_q <= dq_oe;
    dqs_q <= dqs;
  end
  task automatic wb(input logic we, input logic [7:0] a, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    wdat <= 32'h0000_0001;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    stop_test();
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, dq_oe, dqs_oe}, 32'h0000_0000);
    repeat (20000) @(posedge clk_i);
    ctl.send(ddr_dev_pkg::CMD_NOP, 2'h0, 13'h0000);
    ctl.send(ddr_dev_pkg::CMD_PRE, 2'h0, 13'h0400);
    foreach (rows[i]) begin
      ctl.send(ddr_dev_pkg::CMD_MRS, rows[i].ba, rows[i].a);
      repeat (8) @(posedge clk_i);
      wb(1'b0, rows[i].ofs, r);
      chk(r, rows[i].exp);
    end
    $display("test mode registers done");
    repeat (1700) @(posedge clk_i);
    ctl.send(ddr_dev_pkg::CMD_PRE, 2'h0, 13'h0400);
    ctl.send(ddr_dev_pkg::CMD_REF, 2'h0, 13'h0000);
    ctl.send(ddr_dev_pkg::CMD_REF, 2'h0, 13'h0000);
    ctl.send(ddr_dev_pkg::CMD_MRS, 2'h0, 13'h0022);
    ctl.send(ddr_dev_pkg::CMD_RD, 2'h1, 13'h0000);
    repeat (8) @(posedge clk_i);
    wb(1'b0, ddr_dev_pkg::OFS_ERR, r);
    chk(r & 32'h0000_0001, 32'h0000_0001);
    wb(1'b1, ddr_dev_pkg::OFS_ERR, r);
    wb(1'b0, ddr_dev_pkg::OFS_ERR, r);
    chk(r, 32'h0000_0000);
    ctl.send(ddr_dev_pkg::CMD_ACT, 2'h2, 13'h0005);
    repeat (8) @(posedge clk_i);
    wb(1'b0, ddr_dev_pkg::OFS_STATUS, r);
    chk(r & 32'h0000_01ff, 32'h0000_0154);
    ctl.send(ddr_dev_pkg::CMD_WR, 2'h2, 13'h0000);
    ctl.wr4(32'h1312_1110);
    repeat (40) @(posedge clk_i);
    ctl.send(ddr_dev_pkg::CMD_RD, 2'h2, 13'h0001);
    repeat (120) @(posedge clk_i);
    chk(cap_q, 32'h1013_1211);
    $display("test burst wrap done");
    stop_test();
  end
endmodule : ddr_dev_core_test
